// ==== hw/ddcp_regs.vh ====
// Register offsets, field positions and reset values of the down-converter path configuration.
// Included by the path configuration module; definitions only.
`ifndef DDCP_REGS_VH
`define DDCP_REGS_VH
// Printed offsets are not all multiples of four: they are indexes, byte address = 4 * index
`define DDCP_IDX_PATH_CONTROL 12'h310
`define DDCP_IDX_INPUT_SELECT 12'h311
`define DDCP_IDX_OSC_CONTROL 12'h314
`define DDCP_IDX_STATUS 12'h318
`define DDCP_RST_PATH_CONTROL 8'h00
`define DDCP_RST_INPUT_SELECT 8'h00
`define DDCP_RST_OSC_CONTROL 8'h00
// Field positions
`define DDCP_CTL_C2R 3
`define DDCP_CTL_RESV_MASK 8'hF7
`define DDCP_INS_RW_MASK 8'hF5
`define DDCP_INS_QSEL 2
`define DDCP_INS_ISEL 0
// Basic decimation codes
`define DDCP_DEC_EXT 3'h7
// Stage enable bits in the chain vector
`define DDCP_ST_HB1 0
`define DDCP_ST_HB2 1
`define DDCP_ST_HB3 2
`define DDCP_ST_HB4 3
`define DDCP_ST_TB1 4
`define DDCP_ST_TB2 5
`define DDCP_ST_FB2 6
// Oscillator channel select modes
`define DDCP_MODE_DIRECT 4'h0
`define DDCP_MODE_EDGE_A0 4'h8
`define DDCP_MODE_EDGE_B1 4'hB
// AXI responses
`define DDCP_RESP_OKAY 2'h0
`define DDCP_RESP_SLVERR 2'h2
`endif

// ==== hw/ddcp_path_config.v ====
// Configuration decode for one down-converter path: registers, filter chain decode,
// input routing and oscillator channel selection, plus a sample routing stage.
// Assumes one 20 MHz clock, synchronous reset, AXI4-Lite master on the same clock,
// and asynchronous aux pins.
`timescale 1ns/10ps
`include "ddcp_regs.vh"

module ddcp_path_config #(
   parameter SAMPLE_W = 16
)(
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // AXI4-Lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Aux pins for edge-controlled channel selection
   input wire auxPinA0,
   input wire auxPinA1,
   input wire auxPinB0,
   input wire auxPinB1,
   // Converter samples in
   input wire [SAMPLE_W-1:0] chanA,
   input wire [SAMPLE_W-1:0] chanB,
   input wire inValid,
   output reg inReady,
   // Routed samples out
   output reg [SAMPLE_W-1:0] pathI,
   output reg [SAMPLE_W-1:0] pathQ,
   output reg pathQValid,
   output reg outValid,
   input wire outReady,
   // Decoded configuration
   output reg [6:0] stageEnable,
   output reg [5:0] decimRatio,
   output reg chainValid,
   output reg realOnly,
   output reg [3:0] activeOscChan
);

   reg [7:0] ctlReg;
   reg [7:0] inSelReg;
   reg [7:0] oscReg;
   reg [11:0] awAddrReg;
   reg awHeld;
   reg [31:0] wDataReg;
   reg [3:0] wStrbReg;
   reg wHeld;
   reg [3:0] pinMeta;
   reg [3:0] pinStable;
   reg [3:0] pinLast;
   reg [3:0] edgeCount;
   reg [SAMPLE_W-1:0] skidI;
   reg [SAMPLE_W-1:0] skidQ;
   reg [1:0] bufCount;
   reg bufWr;
   reg bufRd;
   reg [6:0] stageNext;
   reg [5:0] ratioNext;
   reg validNext;
   reg [3:0] chanNext;
   wire c2r;
   wire [3:0] pinRaw;
   wire [1:0] edgeSel;
   wire edgeMode;
   wire doWrite;
   wire [11:0] wrIdx;
   wire [11:0] rdIdx;
   wire [SAMPLE_W-1:0] routedI;
   wire [SAMPLE_W-1:0] routedQ;

   // Returns the register index of a byte address, or all ones if unaligned
   function [11:0] byteToIdx;
      input [11:0] addr;
      begin
         if (addr[1:0] != 2'h0)
            byteToIdx = 12'hFFF;
         else
            byteToIdx = {2'h0, addr[11:2]} | 12'h300;
      end
   endfunction

   // Byte lane 0 merge
   function [7:0] lane0;
      input [7:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         lane0 = strb[0] ? data[7:0] : old;
      end
   endfunction

   assign c2r = ctlReg[`DDCP_CTL_C2R];
   assign pinRaw = {auxPinB1, auxPinB0, auxPinA1, auxPinA0};
   assign edgeMode = (oscReg[7:4] >= `DDCP_MODE_EDGE_A0) && (oscReg[7:4] <= `DDCP_MODE_EDGE_B1);
   assign edgeSel = oscReg[5:4];
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign wrIdx = byteToIdx(awAddrReg);
   assign rdIdx = byteToIdx(s_axi_araddr);
   assign routedI = inSelReg[`DDCP_INS_ISEL] ? chanB : chanA;
   // Real mode forces Q to zero so downstream never sees stale quadrature data
   assign routedQ = c2r ? {SAMPLE_W{1'b0}} : (inSelReg[`DDCP_INS_QSEL] ? chanB : chanA);

   // Byte addresses only reach 0x0C60; upper index bits must match 0x3
   // so the decode checks addr[11:10] on their own before the index compare below, as the index forces those bits to ones.

   // Write channel: address and data taken independently, response after both
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrReg <= 12'h000;
         wDataReg <= 32'h00000000;
         wStrbReg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DDCP_RESP_OKAY;
         ctlReg <= `DDCP_RST_PATH_CONTROL;
         inSelReg <= `DDCP_RST_INPUT_SELECT;
         oscReg <= `DDCP_RST_OSC_CONTROL;
      end
      else
      begin
         s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !wHeld && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld <= 1'b1;
            awAddrReg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld <= 1'b1;
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `DDCP_RESP_OKAY;
            if (awAddrReg[11:10] != 2'h3)
               s_axi_bresp <= `DDCP_RESP_SLVERR;
            else if (wrIdx == `DDCP_IDX_PATH_CONTROL)
               ctlReg <= lane0(ctlReg, wDataReg, wStrbReg);
            else if (wrIdx == `DDCP_IDX_INPUT_SELECT)
               inSelReg <= lane0(inSelReg, wDataReg, wStrbReg) & `DDCP_INS_RW_MASK;
            else if (wrIdx == `DDCP_IDX_OSC_CONTROL)
               oscReg <= lane0(oscReg, wDataReg, wStrbReg);
            else if (wrIdx != `DDCP_IDX_STATUS)
               s_axi_bresp <= `DDCP_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one read at a time, data one cycle after the address is taken
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DDCP_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `DDCP_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[11:10] != 2'h3)
               s_axi_rresp <= `DDCP_RESP_SLVERR;
            else if (rdIdx == `DDCP_IDX_PATH_CONTROL)
               s_axi_rdata <= {24'h000000, ctlReg};
            else if (rdIdx == `DDCP_IDX_INPUT_SELECT)
               s_axi_rdata <= {24'h000000, inSelReg};
            else if (rdIdx == `DDCP_IDX_OSC_CONTROL)
               s_axi_rdata <= {24'h000000, oscReg};
            else if (rdIdx == `DDCP_IDX_STATUS)
               s_axi_rdata <= {9'h000, chainValid, realOnly, decimRatio, stageEnable, activeOscChan, edgeCount};
            else
               s_axi_rresp <= `DDCP_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Filter chain and ratio decode; ratios stored for complex output and halved for real, except third-band-first chains, whose ratio is kept
   always @*
   begin
      stageNext = 7'h00;
      ratioNext = 6'h00;
      validNext = 1'b1;
      case (ctlReg[2:0])
         3'h0:
         begin
            stageNext = 7'h03;
            ratioNext = c2r ? 6'd2 : 6'd4;
         end
         3'h1:
         begin
            stageNext = 7'h07;
            ratioNext = c2r ? 6'd4 : 6'd8;
         end
         3'h2:
         begin
            stageNext = 7'h0F;
            ratioNext = c2r ? 6'd8 : 6'd16;
         end
         3'h3:
         begin
            stageNext = 7'h01;
            ratioNext = c2r ? 6'd1 : 6'd2;
         end
         3'h4:
         begin
            stageNext = 7'h21;
            ratioNext = c2r ? 6'd3 : 6'd6;
         end
         3'h5:
         begin
            stageNext = 7'h23;
            ratioNext = c2r ? 6'd6 : 6'd12;
         end
         3'h6:
         begin
            stageNext = 7'h27;
            ratioNext = c2r ? 6'd12 : 6'd24;
         end
         default:
         begin
            // Extended field only consulted here
            case (inSelReg[7:4])
               4'h0:
               begin
                  stageNext = 7'h2F;
                  ratioNext = c2r ? 6'd24 : 6'd48;
               end
               4'h2:
               begin
                  stageNext = 7'h41;
                  ratioNext = c2r ? 6'd5 : 6'd10;
               end
               4'h3:
               begin
                  stageNext = 7'h43;
                  ratioNext = c2r ? 6'd10 : 6'd20;
               end
               4'h4:
               begin
                  stageNext = 7'h47;
                  ratioNext = c2r ? 6'd20 : 6'd40;
               end
               4'h7:
               begin
                  stageNext = 7'h10;
                  ratioNext = 6'd3;
               end
               4'h8:
               begin
                  stageNext = 7'h50;
                  ratioNext = 6'd15;
               end
               4'h9:
               begin
                  stageNext = 7'h52;
                  ratioNext = 6'd30;
               end
               default:
                  validNext = 1'b0;
            endcase
            // Half ratios 1.5, 7.5 and 15 do not exist: real output refused
            if (c2r && inSelReg[7:4] >= 4'h7)
               validNext = 1'b0;
         end
      endcase
   end

   // Aux pins: two-flop synchronisers, then rising edge detect
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         pinMeta <= 4'h0;
         pinStable <= 4'h0;
         pinLast <= 4'h0;
      end
      else
      begin
         pinMeta <= pinRaw;
         pinStable <= pinMeta;
         pinLast <= pinStable;
      end
   end

   // Edge-controlled channel counter
   always @(posedge mclk)
   begin
      if (sys_rst)
         edgeCount <= 4'h0;
      else if (!edgeMode)
         edgeCount <= 4'h0;
      else if (pinStable[edgeSel] && !pinLast[edgeSel])
      begin
         if (edgeCount >= oscReg[3:0])
            edgeCount <= 4'h0;
         else
            edgeCount <= edgeCount + 4'h1;
      end
   end

   always @*
   begin
      if (oscReg[7:4] == `DDCP_MODE_DIRECT)
         chanNext = oscReg[3:0];
      else if (edgeMode)
         chanNext = edgeCount;
      else
         chanNext = oscReg[3:0];
   end

   // Registered configuration outputs
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         stageEnable <= 7'h00;
         decimRatio <= 6'h00;
         chainValid <= 1'b0;
         realOnly <= 1'b0;
         activeOscChan <= 4'h0;
      end
      else
      begin
         stageEnable <= stageNext;
         decimRatio <= ratioNext;
         chainValid <= validNext;
         realOnly <= c2r;
         activeOscChan <= chanNext;
      end
   end

   // Two-entry buffer: pathI/pathQ hold the head, a skid entry sits behind it so a stall loses no word
   always @*
   begin
      bufWr = inValid && inReady;
      bufRd = outValid && outReady;
   end

   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         bufCount <= 2'h0;
         inReady <= 1'b0;
         outValid <= 1'b0;
         pathI <= {SAMPLE_W{1'b0}};
         pathQ <= {SAMPLE_W{1'b0}};
         pathQValid <= 1'b0;
         skidI <= {SAMPLE_W{1'b0}};
         skidQ <= {SAMPLE_W{1'b0}};
      end
      else
      begin
         pathQValid <= !c2r;
         // A full buffer never accepts, so a write with two words held cannot occur
         if (bufRd && bufCount == 2'h2)
         begin
            pathI <= skidI;
            pathQ <= skidQ;
         end
         else if (bufWr && (bufCount == 2'h0 || bufRd))
         begin
            pathI <= routedI;
            pathQ <= routedQ;
         end
         if (bufWr && bufCount == 2'h1 && !bufRd)
         begin
            skidI <= routedI;
            skidQ <= routedQ;
         end
         case ({bufWr, bufRd})
            2'b10: bufCount <= bufCount + 2'h1;
            2'b01: bufCount <= bufCount - 2'h1;
            default: bufCount <= bufCount;
         endcase
         inReady <= (bufCount + (bufWr ? 2'h1 : 2'h0) - (bufRd ? 2'h1 : 2'h0)) < 2'h2;
         outValid <= (bufCount + (bufWr ? 2'h1 : 2'h0) - (bufRd ? 2'h1 : 2'h0)) != 2'h0;
      end
   end

endmodule

// ==== tb/ddcp_path_config_asserts.sv ====
// Checker for the down-converter path configuration block.
// Sees only top-level ports; bound to every instance of the block.
`timescale 1ns/10ps
module ddcp_path_config_asserts (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Register bus
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // Stream
   input wire outValid,
   input wire outReady,
   input wire pathQValid,
   // Decoded configuration
   input wire [6:0] stageEnable,
   input wire [5:0] decimRatio,
   input wire chainValid,
   input wire realOnly
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   // Ratio is the product of the enabled stage factors, halved for real output
   function automatic int prodOf(input logic [6:0] s, input logic r);
      int p;
      p = 1;
      for (int i = 0; i < 4; i++)
         if (s[i]) p = p * 2;
      if (s[4]) p = p * 3;
      if (s[5]) p = p * 3;
      if (s[6]) p = p * 5;
      return r ? p / 2 : p;
   endfunction

   chk_q_dropped: assert property (realOnly && $past(realOnly) |-> !pathQValid)
      else $error("Q valid while real output selected");
   chk_ratio_product: assert property (chainValid |-> decimRatio == prodOf(stageEnable, realOnly))
      else $error("decimation ratio does not match stage chain");
   chk_real_unsupported: assert property (realOnly && stageEnable[4] |-> !chainValid)
      else $error("halved third-band ratio flagged valid");
   chk_halfband_contig: assert property (chainValid && !stageEnable[4] |-> stageEnable[3:0] inside {4'h1, 4'h3, 4'h7, 4'hF})
      else $error("half-band stages not contiguous from stage one");
   chk_thirdband_alone: assert property (chainValid && stageEnable[5] |-> !stageEnable[6] && !stageEnable[4])
      else $error("second third-band stage combined with fifth-band");
   chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while response pending");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   chk_stall_holds: assert property (outValid && !outReady |=> outValid)
      else $error("output word dropped during stall");

   cover property (realOnly && chainValid);
   cover property (chainValid && stageEnable[6]);
   cover property (outValid && !outReady);
endmodule

bind ddcp_path_config ddcp_path_config_asserts ddcp_path_config_asserts_inst (.mclk(mclk), .sys_rst(sys_rst),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .outValid(outValid), .outReady(outReady),
   .pathQValid(pathQValid), .stageEnable(stageEnable), .decimRatio(decimRatio), .chainValid(chainValid),
   .realOnly(realOnly));

// ==== tb/tb_ddcp_path_config.sv ====
// Self-checking bench for the down-converter path configuration block.
// Drives AXI4-Lite, aux pins and the sample stream; one 20 MHz clock.
`timescale 1ns/10ps
module tb_ddcp_path_config;
   logic mclk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb, aux;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic [15:0] chanA, chanB;
   logic inValid, outReady;
   wire inReady, outValid, pathQValid, chainValid, realOnly;
   wire [6:0] stageEnable;
   wire [5:0] decimRatio;
   wire [15:0] pathI, pathQ;
   logic [31:0] sq[$];
   logic [31:0] snote;
   int miscompares, totalChecks, cnt;
   logic [1:0] bq[$];
   logic [65:0] rq[$];
   logic [65:0] note;
   logic [7:0] rnd, ctl, ins;

   ddcp_path_config ddcp_path_config_inst (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .auxPinA0(aux[0]), .auxPinA1(aux[1]), .auxPinB0(aux[2]),
      .auxPinB1(aux[3]), .chanA(chanA), .chanB(chanB), .inValid(inValid), .inReady(inReady), .pathI(pathI),
      .pathQ(pathQ), .pathQValid(pathQValid), .outValid(outValid), .outReady(outReady),
      .stageEnable(stageEnable), .decimRatio(decimRatio), .chainValid(chainValid), .realOnly(realOnly),
      .activeOscChan());

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Stages {FB2,TB2,TB1,HB4..HB1} and complex ratio; 0-6 basic codes, 7-13 extended
   function automatic logic [12:0] chain(input int k);
      case (k)
         0: return {7'h03, 6'h04};
         1: return {7'h07, 6'h08};
         2: return {7'h0F, 6'h10};
         3: return {7'h01, 6'h02};
         4: return {7'h21, 6'h06};
         5: return {7'h23, 6'h0C};
         6: return {7'h27, 6'h18};
         7: return {7'h2F, 6'h30};
         8: return {7'h41, 6'h0A};
         9: return {7'h43, 6'h14};
         10: return {7'h47, 6'h28};
         11: return {7'h10, 6'h03};
         12: return {7'h50, 6'h0F};
         default: return {7'h52, 6'h1E};
      endcase
   endfunction

   // Third-band-first chains cannot be halved: ratio kept, chain flagged invalid
   function automatic logic [31:0] stat(input int k, input logic r);
      logic [12:0] c;
      logic [5:0] ratio;
      c = chain(k);
      ratio = (r && k < 11) ? {1'b0, c[5:1]} : c[5:0];
      return {9'h000, !(r && k >= 11), r, ratio, c[12:6], 8'h00};
   endfunction

   // Address and data channels are released independently, each at the edge its own ready is seen
   task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic awPend, wPend;
      @(posedge mclk);
      bq.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      awPend = 1'b1;
      wPend = 1'b1;
      while (awPend || wPend)
      begin
         @(posedge mclk);
         if (awPend && s_axi_awready)
         begin
            awPend = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wPend && s_axi_wready)
         begin
            wPend = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge mclk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
      @(posedge mclk);
      rq.push_back({m, ed & m, er});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   task automatic pulse(input int p);
      @(posedge mclk);
      aux[p] <= 1'b1;
      repeat (3) @(posedge mclk);
      aux[p] <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   // Responses are compared against the oldest note of the issuing task
   always @(posedge mclk)
   begin
      if (s_axi_bvalid && s_axi_bready) check("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
      if (s_axi_rvalid && s_axi_rready)
      begin
         note = rq.pop_front();
         check("rresp", {30'h0, note[1:0]}, {30'h0, s_axi_rresp});
         check("rdata", note[33:2], s_axi_rdata & note[65:34]);
      end
      if (inValid && inReady)
         sq.push_back({ins[0] ? chanB : chanA, ctl[3] ? 16'h0000 : ins[2] ? chanB : chanA});
      if (outValid && outReady)
      begin
         snote = sq.pop_front();
         check("pathI", {16'h0, snote[31:16]}, {16'h0, pathI});
         check("pathQ", {16'h0, snote[15:0]}, {16'h0, pathQ});
         check("pathQValid", {31'h0, !ctl[3]}, {31'h0, pathQValid});
      end
   end

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      print_verdict();
   end

   initial
   begin
      {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, aux, chanA, chanB} = 92'h0;
      s_axi_wstrb = 4'hF;
      inValid = 1'b0;
      outReady = 1'b1;
      void'($urandom(32'hF57766B4));
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      axr(12'hC40, 32'h0, 32'hFF, 2'h0);
      axr(12'hC44, 32'h0, 32'hFF, 2'h0);
      axr(12'hC50, 32'h0, 32'hFF, 2'h0);
      axr(12'hC60, stat(0, 1'b0), 32'h007FFF00, 2'h0);
      for (int k = 0; k < 14; k++)
         for (int r = 0; r < 2; r++)
         begin
            rnd = 8'($urandom);
            ins = (k < 7) ? rnd : {4'((k == 7) ? 0 : (k <= 10) ? k - 6 : k - 4), rnd[3:0]};
            ctl = {rnd[7:4], r[0], (k < 7) ? k[2:0] : 3'h7};
            axw(12'hC44, ins, 2'h0);
            axw(12'hC40, ctl, 2'h0);
            axr(12'hC44, {24'h0, ins & 8'hF5}, 32'hFF, 2'h0);
            axr(12'hC40, {24'h0, ctl}, 32'hFF, 2'h0);
            axr(12'hC60, stat(k, r[0]), 32'h007FFF00, 2'h0);
         end
      // Complex mode with random routing so both selectors and the Q path are seen
      ins = 8'($urandom) & 8'hF5;
      ctl = 8'h00;
      axw(12'hC44, ins, 2'h0);
      axw(12'hC40, ctl, 2'h0);
      cnt = 0;
      outReady <= 1'b0;
      inValid <= 1'b1;
      chanA <= 16'($urandom);
      chanB <= 16'($urandom);
      repeat (8)
      begin
         @(posedge mclk);
         if (inReady) cnt++;
         chanA <= 16'($urandom);
         chanB <= 16'($urandom);
      end
      inValid <= 1'b0;
      check("fill", 32'h2, cnt);
      cnt = 0;
      outReady <= 1'b1;
      repeat (8) @(posedge mclk) if (outValid) cnt++;
      check("drain", 32'h2, cnt);
      for (int i = 0; i < 4; i++)
      begin
         rnd = 8'($urandom);
         axw(12'hC50, {4'h0, rnd[3:0]}, 2'h0);
         axr(12'hC60, {24'h0, rnd[3:0], 4'h0}, 32'hF0, 2'h0);
      end
      // Five edges on the selected pin wrap at three; an edge elsewhere is ignored
      for (int m = 0; m < 4; m++)
      begin
         axw(12'hC50, 8'h00, 2'h0);
         axw(12'hC50, {2'h2, m[1:0], 4'h3}, 2'h0);
         repeat (5) pulse(m);
         pulse((m + 1) % 4);
         axr(12'hC60, 32'h1, 32'h0F, 2'h0);
      end
      axw(12'hC48, 8'hFF, 2'h2);
      axr(12'hC48, 32'h0, 32'hFFFFFFFF, 2'h2);
      print_verdict();
   end
endmodule
